// ---- adc_cfg_regs.vh ----
`ifndef ADC_CFG_REGS_VH
`define ADC_CFG_REGS_VH

// register byte addresses (offsets 0xb12, 0xb0a are not word multiples, so index*4)
`define IDX_MODE_LOW 12'hb10
`define IDX_MODE_HIGH 12'hb12
`define IDX_CLK_CTRL 12'hb0a
`define ADDR_W 14
`define ADDR_MODE_LOW 14'h2c40
`define ADDR_MODE_HIGH 14'h2c48
`define ADDR_CLK_CTRL 14'h2c28

// clock control fields
`define SRC_SEL_HI 15
`define SRC_SEL_LO 14
`define DIV_HI 13
`define DIV_LO 8
`define SHARED_EN_BIT 7
// only the enable bit lives in the low byte, the rest reads zero
`define CLK_CTRL_LOW_MASK 8'h80

// source select codes
`define SRC_OSC 2'h0
`define SRC_CYC 2'h1
`define SRC_VCO3 2'h2
`define SRC_VCO4 2'h3

// reset values
`define RST_MODE 16'h0000
`define RST_CLK_CTRL 16'h0000

// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- adc_clock_and_input_mode_config.v ----
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg_regs.vh"

// Operation
// - Bits 15:14 of the clock control register pick oscillator, cycle, vco/3 or vco/4.
// - Bits 13:8 divide the chosen source by field value plus one to make the core source clock.
// - The divided core source clock goes out to every converter core, all cores getting the same tick from the one divider.
// - Bit 7 enables the shared core, and a zero holds it disabled.
// - A channel's differential bit set means differential conversion, clear means single-ended.
// - A channel's sign bit set means signed result data, clear means unsigned.
// - The low mode register holds channels 0 to 7, diff at bit 2n+1 and sign at 2n, reset zero.
// - The high mode register holds channels 8 to 15 in the same pairing, reset zero.
module adc_clock_and_input_mode_config #(
    parameter NUM_CORES = 2,
    parameter NUM_CH = 16
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // clock sources, each a single-cycle enable tick from the clock tree
    input wire osc_tick,
    input wire cyc_tick,
    input wire vco_div3_tick,
    input wire vco_div4_tick,
    // axi4-lite write
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // converter side
    output reg [NUM_CORES-1:0] core_src_tick,
    output reg shared_core_enable,
    output reg [NUM_CH-1:0] channel_differential_mode,
    output reg [NUM_CH-1:0] channel_signed_output
);

    reg [15:0] clk_ctrl_q;
    reg [15:0] mode_low_q;
    reg [15:0] mode_high_q;
    reg [5:0] div_cnt_q;
    reg [1:0] osc_s_q, cyc_s_q, vco3_s_q, vco4_s_q;
    reg aw_held_q, w_held_q;
    reg [`ADDR_W-1:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg src_tick;
    wire [1:0] src_sel;
    wire [5:0] div_val;
    wire do_write;
    wire [`ADDR_W-1:0] waddr;
    wire [31:0] wdata;
    wire [3:0] wstrb;
    // both mode registers side by side, low register in the low half
    wire [31:0] mode_pair;
    wire [NUM_CH-1:0] diff_d;
    wire [NUM_CH-1:0] sign_d;
    genvar gi;

    // source ticks come from other clock trees, so two flops first
    always @(posedge aclk) begin
        if (!aresetn) begin
            osc_s_q <= 2'h0;
            cyc_s_q <= 2'h0;
            vco3_s_q <= 2'h0;
            vco4_s_q <= 2'h0;
        end else begin
            osc_s_q <= {osc_s_q[0], osc_tick};
            cyc_s_q <= {cyc_s_q[0], cyc_tick};
            vco3_s_q <= {vco3_s_q[0], vco_div3_tick};
            vco4_s_q <= {vco4_s_q[0], vco_div4_tick};
        end
    end

    assign src_sel = clk_ctrl_q[`SRC_SEL_HI:`SRC_SEL_LO];
    assign div_val = clk_ctrl_q[`DIV_HI:`DIV_LO];

    always @* begin
        case (src_sel)
            `SRC_OSC: src_tick = osc_s_q[1];
            `SRC_CYC: src_tick = cyc_s_q[1];
            `SRC_VCO3: src_tick = vco3_s_q[1];
            default: src_tick = vco4_s_q[1];
        endcase
    end

    // divide by field plus one; one output tick per div_val+1 source ticks
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_q <= 6'h00;
            core_src_tick <= {NUM_CORES{1'b0}};
        end else if (src_tick) begin
            if (div_cnt_q >= div_val) begin
                div_cnt_q <= 6'h00;
                // same tick fans out to every core
                core_src_tick <= {NUM_CORES{1'b1}};
            end else begin
                div_cnt_q <= div_cnt_q + 6'h01;
                core_src_tick <= {NUM_CORES{1'b0}};
            end
        end else begin
            core_src_tick <= {NUM_CORES{1'b0}};
        end
    end

    // register outputs toward the converter
    always @(posedge aclk) begin
        if (!aresetn) begin
            shared_core_enable <= 1'b0;
        end else begin
            // zero holds the shared core off
            shared_core_enable <= clk_ctrl_q[`SHARED_EN_BIT];
        end
    end

    // per-channel pairing: diff odd bit, sign even bit; no more than 16 channels fit
    assign mode_pair = {mode_high_q, mode_low_q};
    generate
        for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_ch
            assign diff_d[gi] = mode_pair[2*gi+1];
            assign sign_d[gi] = mode_pair[2*gi];
        end
    endgenerate

    // one process for all channels, so each output vector has a single driver
    always @(posedge aclk) begin
        if (!aresetn) begin
            channel_differential_mode <= {NUM_CH{1'b0}};
            channel_signed_output <= {NUM_CH{1'b0}};
        end else begin
            channel_differential_mode <= diff_d;
            channel_signed_output <= sign_d;
        end
    end

    // write side: address and data taken in either order, held until both
    assign waddr = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : aw_addr_q;
    assign wdata = s_axi_wvalid && s_axi_wready ? s_axi_wdata : w_data_q;
    assign wstrb = s_axi_wvalid && s_axi_wready ? s_axi_wstrb : w_strb_q;
    assign do_write = (aw_held_q || (s_axi_awvalid && s_axi_awready))
        && (w_held_q || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= {`ADDR_W{1'b0}};
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            clk_ctrl_q <= `RST_CLK_CTRL;
            mode_low_q <= `RST_MODE;
            mode_high_q <= `RST_MODE;
        end else begin
            // ready one cycle, only when that channel is not already held
            s_axi_awready <= !s_axi_awready && !aw_held_q && !s_axi_bvalid
                && s_axi_awvalid && !do_write;
            s_axi_wready <= !s_axi_wready && !w_held_q && !s_axi_bvalid
                && s_axi_wvalid && !do_write;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                // no lockout: software keeps the converter off while changing these
                if (waddr == `ADDR_CLK_CTRL) begin
                    if (wstrb[0]) clk_ctrl_q[7:0] <= wdata[7:0] & `CLK_CTRL_LOW_MASK;
                    if (wstrb[1]) clk_ctrl_q[15:8] <= wdata[15:8];
                end else if (waddr == `ADDR_MODE_LOW) begin
                    if (wstrb[0]) mode_low_q[7:0] <= wdata[7:0];
                    if (wstrb[1]) mode_low_q[15:8] <= wdata[15:8];
                end else if (waddr == `ADDR_MODE_HIGH) begin
                    if (wstrb[0]) mode_high_q[7:0] <= wdata[7:0];
                    if (wstrb[1]) mode_high_q[15:8] <= wdata[15:8];
                end else begin
                    s_axi_bresp <= `RESP_SLVERR;
                end
            end else begin
                if (s_axi_awvalid && s_axi_awready) aw_held_q <= 1'b1;
                if (s_axi_wvalid && s_axi_wready) w_held_q <= 1'b1;
                if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read side: arready one cycle, data the cycle after
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                if (s_axi_araddr == `ADDR_CLK_CTRL) begin
                    s_axi_rdata <= {16'h0000, clk_ctrl_q};
                end else if (s_axi_araddr == `ADDR_MODE_LOW) begin
                    s_axi_rdata <= {16'h0000, mode_low_q};
                end else if (s_axi_araddr == `ADDR_MODE_HIGH) begin
                    s_axi_rdata <= {16'h0000, mode_high_q};
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // adc_clock_and_input_mode_config
`default_nettype wire

// ---- adc_cfg_checker_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_cfg_checker #(
    parameter NUM_CORES = 2,
    parameter NUM_CH = 16
) (
    // clock, reset and sources
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic osc_tick,
    input wire logic cyc_tick,
    input wire logic vco_div3_tick,
    input wire logic vco_div4_tick,
    // bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // converter side
    input wire logic [NUM_CORES-1:0] core_src_tick,
    input wire logic shared_core_enable,
    input wire logic [NUM_CH-1:0] channel_differential_mode,
    input wire logic [NUM_CH-1:0] channel_signed_output
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // any source, seen late through the synchroniser
    wire src_any = osc_tick | cyc_tick | vco_div3_tick | vco_div4_tick;
    AST_TICK_CAUSE: assert property (core_src_tick[0] |->
        $past(src_any, 2) || $past(src_any, 3) || $past(src_any, 4) || $past(src_any, 5))
        else $error("core tick without a source tick");
    // a source held high for two cycles legally gives two ticks, so a tick is checked only when no source was high the cycle before
    AST_TICK_PULSE: assert property (core_src_tick[0] && !$past(src_any) |=> !core_src_tick[0])
        else $error("core tick longer than one cycle");
    AST_TICK_EQ: assert property (core_src_tick == {NUM_CORES{core_src_tick[0]}})
        else $error("cores see different ticks");
    AST_EN_CAUSE: assert property ($changed(shared_core_enable) |-> $past(s_axi_bvalid))
        else $error("enable moved without a write");
    AST_DIFF_CAUSE: assert property ($changed(channel_differential_mode) |->
        $past(s_axi_bvalid)) else $error("diff mode moved without a write");
    AST_SIGN_CAUSE: assert property ($changed(channel_signed_output) |->
        $past(s_axi_bvalid)) else $error("sign mode moved without a write");
    AST_RDATA_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
        else $error("upper read half not zero");
    // address and data come in either order; the later one is taken just before the answer
    AST_BRESP_AFTER_W: assert property ($rose(s_axi_bvalid) |->
        $past(s_axi_wready) || $past(s_axi_awready))
        else $error("write answer without data taken");
    // main scenarios reached
    cover property (core_src_tick[0]);
    cover property ($rose(shared_core_enable));
    cover property (s_axi_rvalid && s_axi_rdata != 32'h0);
endmodule // adc_cfg_checker
bind adc_clock_and_input_mode_config adc_cfg_checker #(.NUM_CORES(NUM_CORES), .NUM_CH(NUM_CH))
    i_adc_cfg_checker (.aclk(aclk), .aresetn(aresetn), .osc_tick(osc_tick),
    .cyc_tick(cyc_tick), .vco_div3_tick(vco_div3_tick), .vco_div4_tick(vco_div4_tick),
    .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rdata(s_axi_rdata), .core_src_tick(core_src_tick),
    .shared_core_enable(shared_core_enable),
    .channel_differential_mode(channel_differential_mode),
    .channel_signed_output(channel_signed_output));
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "adc_cfg_regs.vh"
module testbench;
    logic aclk = 0;
    logic aresetn = 0;
    logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
    logic [3:0] src = 4'h0, strb = 4'h0;
    logic [13:0] aw_a = 14'h0, ar_a = 14'h0;
    logic [31:0] w_d = 32'h0;
    wire aw_rdy, w_rdy, b_v, ar_rdy, r_v, en;
    wire [1:0] b_resp, r_resp, tk;
    wire [31:0] r_d;
    wire [15:0] dm, sg;
    int mismatches = 0, cmp_count = 0, cyc = 0, ticks = 0, t0 = 0;
    int divs[4] = '{0, 2, 5, 63};
    adc_clock_and_input_mode_config i_adc_clock_and_input_mode_config (
        .aclk(aclk), .aresetn(aresetn), .osc_tick(src[0]), .cyc_tick(src[1]),
        .vco_div3_tick(src[2]), .vco_div4_tick(src[3]), .s_axi_awaddr(aw_a),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(strb),
        .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
        .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
        .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
        .core_src_tick(tk), .shared_core_enable(en), .channel_differential_mode(dm),
        .channel_signed_output(sg));
    // 200 mhz clock
    initial forever #2.5 aclk = ~aclk;
    // core tick count, and a ceiling well above the longest divider sweep
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (tk[0] === 1'b1) ticks <= ticks + 1;
        if (cyc == 8000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask
    // leading edge keeps two tasks from driving one signal in one step
    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        @(posedge aclk);
        aw_a <= a;
        w_d <= d;
        strb <= s;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        do begin
            @(posedge aclk);
            if (aw_rdy) aw_v <= 1'b0;
            if (w_rdy) w_v <= 1'b0;
        end while (b_v !== 1'b1);
        b_r <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, b_resp});
    endtask
    task automatic rd(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do begin
            @(posedge aclk);
            if (ar_rdy) ar_v <= 1'b0;
        end while (r_v !== 1'b1);
        r_r <= 1'b0;
        chk("rdata", e, r_d);
        chk("rresp", {30'h0, er}, {30'h0, r_resp});
    endtask
    // odd bits pick differential, even bits signed
    task automatic outs(input logic [15:0] l, input logic [15:0] h);
        logic [15:0] ed, es;
        for (int i = 0; i < 8; i++) begin
            ed[i] = l[2*i+1];
            ed[i+8] = h[2*i+1];
            es[i] = l[2*i];
            es[i+8] = h[2*i];
        end
        repeat (2) @(posedge aclk);
        chk("diff", {16'h0, ed}, {16'h0, dm});
        chk("sign", {16'h0, es}, {16'h0, sg});
    endtask
    task automatic end_of_test();
        $display("mismatches %0d compares %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ADDR_MODE_LOW, 32'h0, `RESP_OKAY);
        rd(`ADDR_MODE_HIGH, 32'h0, `RESP_OKAY);
        rd(`ADDR_CLK_CTRL, 32'h0, `RESP_OKAY);
        outs(16'h0, 16'h0);
        wr(`ADDR_MODE_LOW, 32'h00009c36, 4'hf, `RESP_OKAY);
        wr(`ADDR_MODE_HIGH, 32'hffff63c9, 4'hf, `RESP_OKAY);
        rd(`ADDR_MODE_HIGH, 32'h000063c9, `RESP_OKAY);
        outs(16'h9c36, 16'h63c9);
        wr(`ADDR_MODE_LOW, 32'h0000fff0, 4'h1, `RESP_OKAY);
        rd(`ADDR_MODE_LOW, 32'h00009cf0, `RESP_OKAY);
        wr(14'h2c44, 32'h0000ffff, 4'hf, `RESP_SLVERR);
        rd(14'h2c44, 32'h0, `RESP_SLVERR);
        wr(`ADDR_CLK_CTRL, 32'h000000ff, 4'hf, `RESP_OKAY);
        rd(`ADDR_CLK_CTRL, 32'h00000080, `RESP_OKAY);
        chk("enable", 32'h1, {31'h0, en});
        wr(`ADDR_CLK_CTRL, 32'h0, 4'hf, `RESP_OKAY);
        // each source with the others toggling; four core ticks expected
        for (int s = 0; s < 4; s++) begin
            wr(`ADDR_CLK_CTRL, {16'h0, s[1:0], divs[s][5:0], 8'h00}, 4'hf, `RESP_OKAY);
            t0 = ticks;
            for (int k = 0; k < 16 * (divs[s] + 1); k++) begin
                @(posedge aclk);
                src <= (k % 4 == 0) ? 4'h1 << s : ((k % 2) ? ~(4'h1 << s) : 4'h0);
            end
            @(posedge aclk);
            src <= 4'h0;
            repeat (8) @(posedge aclk);
            chk("core ticks", 32'h4, ticks - t0);
        end
        chk("enable off", 32'h0, {31'h0, en});
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
